// file: src/otp_program_sequencer.sv
`timescale 1ns/10ps
module otp_program_sequencer (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    start,
  input  wire logic                    page,
  input  wire logic                    otp_done,
  output logic                         busy,
  output logic                         done,
  output otp_unlock_pkg::otp_prog_t    otp_prog
);
  import otp_unlock_pkg::*;

  seq_state_t state_reg;
  seq_state_t state_next;
  logic       page_reg;
  logic       page_next;

  // Next state; the page is frozen at start so a later write cannot retarget it
  always_comb begin
    state_next = state_reg;
    page_next  = page_reg;
    case (state_reg)
      SEQ_IDLE: begin
        if (start) begin
          state_next = SEQ_PROGRAM;
          page_next  = page;
        end
      end
      SEQ_PROGRAM: begin
        if (otp_done) begin
          state_next = SEQ_FINISH;
        end
      end
      SEQ_FINISH: begin
        state_next = SEQ_IDLE;
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SEQ_IDLE;
      page_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      page_reg  <= page_next;
    end
  end

  // Busy covers the finish cycle so start reads one until done is reported
  assign busy          = (state_reg != SEQ_IDLE);
  assign done          = (state_reg == SEQ_FINISH);
  assign otp_prog.req  = (state_reg == SEQ_PROGRAM);
  assign otp_prog.page = page_reg;

endmodule : otp_program_sequencer

// file: src/otp_program_unlock_control.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`include "otp_unlock_params.svh"

module otp_program_unlock_control #(
  parameter logic [31:0] KEY_ONE_CODE = 32'h11111111,
  parameter logic [31:0] KEY_TWO_CODE = 32'h22222222
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire otp_unlock_pkg::ecc_event_t ecc_event,
  input  wire logic                     otp_done,
  output otp_unlock_pkg::otp_prog_t     otp_prog,
  output logic                          irq
);
  import otp_unlock_pkg::*;

  // Bus data phase tracking
  logic                 wr_pend_reg;
  logic                 wr_pend_next;
  logic                 rd_wait_reg;
  logic                 rd_wait_next;
  logic [`IDX_W-1:0]    dp_idx_reg;
  logic [`IDX_W-1:0]    dp_idx_next;
  logic                 dp_map_reg;
  logic                 dp_map_next;
  logic [31:0]          hrdata_reg;
  logic [31:0]          hrdata_next;

  // Key entry
  logic [31:0]          key_one_reg;
  logic [31:0]          key_one_next;
  logic [31:0]          key_two_reg;
  logic [31:0]          key_two_next;
  logic [2:0]           stage_one_reg;
  logic [2:0]           stage_one_next;
  logic [2:0]           stage_two_reg;
  logic [2:0]           stage_two_next;

  // Control, logs and interrupts
  logic                 page_reg;
  logic                 page_next;
  logic [7:0]           sec_log_reg;
  logic [7:0]           sec_log_next;
  logic [7:0]           ded_log_reg;
  logic [7:0]           ded_log_next;
  logic [`IRQ_W-1:0]    status_reg;
  logic [`IRQ_W-1:0]    status_next;
  logic [`IRQ_W-1:0]    mask_reg;
  logic [`IRQ_W-1:0]    mask_next;

  // Decoded strobes and engine handshake
  logic                 accept;
  logic                 wr_strobe;
  logic [7:0]           wr_byte;
  logic                 start_req;
  logic                 keys_ok;
  logic                 seq_start;
  logic                 seq_busy;
  logic                 seq_done;
  logic [`IRQ_W-1:0]    hw_set;
  logic                 ctrl_wr;
  logic                 status_wr;
  logic                 mask_wr;

  // Slot of a key byte register: {hit, byte number}, byte a is number zero
  function automatic logic [2:0] key_slot(
    input logic [`IDX_W-1:0] idx,
    input logic [`IDX_W-1:0] base
  );
    logic [`IDX_W-1:0] off;
    off = idx - base;
    if (idx >= base && off < `IDX_W'(4)) begin
      key_slot = {1'b1, off[1:0]};
    end else begin
      key_slot = 3'h0;
    end
  endfunction : key_slot

  // Next entry stage: only the expected byte advances, byte a always restarts
  function automatic logic [2:0] next_stage(
    input logic [2:0] stage,
    input logic [1:0] num
  );
    if (num == 2'h0) begin
      next_stage = 3'h1;
    end else if ({1'b0, num} == stage) begin
      next_stage = stage + 3'h1;
    end else begin
      next_stage = `RST_STAGE;
    end
  endfunction : next_stage

  // Place one byte into the key; byte a is the most significant
  function automatic logic [31:0] put_byte(
    input logic [31:0] key,
    input logic [1:0]  num,
    input logic [7:0]  data
  );
    logic [31:0] res;
    res = key;
    case (num)
      2'h0: res[31:24] = data;
      2'h1: res[23:16] = data;
      2'h2: res[15:8]  = data;
      default: res[7:0] = data;
    endcase
    put_byte = res;
  endfunction : put_byte

  // Write strobe aimed at one register index
  function automatic logic wr_hit(
    input logic              wr,
    input logic [`IDX_W-1:0] idx,
    input logic [`IDX_W-1:0] target
  );
    wr_hit = wr && (idx == target);
  endfunction : wr_hit

  // Address phase taken only on a valid transfer with the bus ready
  assign accept    = hsel && htrans[1] && hready;
  assign wr_strobe = wr_pend_reg && dp_map_reg;
  assign wr_byte   = hwdata[7:0];

  // Per-register write strobes in the data phase
  assign ctrl_wr   = wr_hit(wr_strobe, dp_idx_reg, `IDX_PROG_CTRL);
  assign status_wr = wr_hit(wr_strobe, dp_idx_reg, `IDX_IRQ_STATUS);
  assign mask_wr   = wr_hit(wr_strobe, dp_idx_reg, `IDX_IRQ_MASK);

  // Bus phase bookkeeping; reads take one wait state so a write just ahead is seen
  always_comb begin
    wr_pend_next = 1'b0;
    rd_wait_next = 1'b0;
    dp_idx_next  = dp_idx_reg;
    dp_map_next  = dp_map_reg;
    if (accept) begin
      wr_pend_next = hwrite;
      rd_wait_next = !hwrite;
      dp_idx_next  = haddr[`IDX_W+1:2];
      dp_map_next  = (haddr[31:`IDX_W+2] == '0) && (haddr[1:0] == 2'h0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      dp_idx_reg  <= '0;
      dp_map_reg  <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_wait_reg <= rd_wait_next;
      dp_idx_reg  <= dp_idx_next;
      dp_map_reg  <= dp_map_next;
    end
  end

  // Read mux, sampled in the wait state; unmapped and reserved bits read zero
  always_comb begin
    hrdata_next = hrdata_reg;
    if (rd_wait_reg) begin
      hrdata_next = 32'h00000000;
      if (!dp_map_reg) begin
        hrdata_next = 32'h00000000;
      end else if (dp_idx_reg == `IDX_PROG_CTRL) begin
        hrdata_next[`CTRL_PAGE_BIT]  = page_reg;
        hrdata_next[`CTRL_START_BIT] = seq_busy;
      end else if (dp_idx_reg == `IDX_SEC_LOG) begin
        hrdata_next[7:0] = sec_log_reg;
      end else if (dp_idx_reg == `IDX_DED_LOG) begin
        hrdata_next[7:0] = ded_log_reg;
      end else if (dp_idx_reg == `IDX_IRQ_STATUS) begin
        hrdata_next[`IRQ_W-1:0] = status_reg;
      end else if (dp_idx_reg == `IDX_IRQ_MASK) begin
        hrdata_next[`IRQ_W-1:0] = mask_reg;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  // Slave answers: wait state on reads only, always OKAY
  assign hrdata    = hrdata_reg;
  assign hreadyout = !rd_wait_reg;
  assign hresp     = 1'b0;

  // Start request and key check; a start while busy is ignored, not queued
  assign start_req = ctrl_wr && wr_byte[`CTRL_START_BIT] && !seq_busy;
  assign keys_ok   = (stage_one_reg == `STAGE_FULL) && (key_one_reg == KEY_ONE_CODE)
                     && (stage_two_reg == `STAGE_FULL) && (key_two_reg == KEY_TWO_CODE);
  assign seq_start = start_req && keys_ok;

  // Key capture; any start attempt while idle relocks so each programming needs fresh keys
  always_comb begin
    logic [2:0] slot_one;
    logic [2:0] slot_two;
    slot_one       = key_slot(dp_idx_reg, `IDX_KEY_ONE_A);
    slot_two       = key_slot(dp_idx_reg, `IDX_KEY_TWO_A);
    key_one_next   = key_one_reg;
    key_two_next   = key_two_reg;
    stage_one_next = stage_one_reg;
    stage_two_next = stage_two_reg;
    if (start_req) begin
      key_one_next   = `RST_KEY;
      key_two_next   = `RST_KEY;
      stage_one_next = `RST_STAGE;
      stage_two_next = `RST_STAGE;
    end else if (wr_strobe && slot_one[2]) begin
      key_one_next   = put_byte(key_one_reg, slot_one[1:0], wr_byte);
      stage_one_next = next_stage(stage_one_reg, slot_one[1:0]);
    end else if (wr_strobe && slot_two[2]) begin
      key_two_next   = put_byte(key_two_reg, slot_two[1:0], wr_byte);
      stage_two_next = next_stage(stage_two_reg, slot_two[1:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_one_reg   <= `RST_KEY;
      key_two_reg   <= `RST_KEY;
      stage_one_reg <= `RST_STAGE;
      stage_two_reg <= `RST_STAGE;
    end else begin
      key_one_reg   <= key_one_next;
      key_two_reg   <= key_two_next;
      stage_one_reg <= stage_one_next;
      stage_two_reg <= stage_two_next;
    end
  end

  // Page select; held while busy because the engine already froze its copy
  always_comb begin
    page_next = page_reg;
    mask_next = mask_reg;
    if (ctrl_wr && !seq_busy) begin
      page_next = wr_byte[`CTRL_PAGE_BIT];
    end
    if (mask_wr) begin
      mask_next = wr_byte[`IRQ_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_reg <= 1'b0;
      mask_reg <= `RST_IRQ;
    end else begin
      page_reg <= page_next;
      mask_reg <= mask_next;
    end
  end

  // Error address logs follow the latest event of their kind; sec and ded in one cycle both update
  always_comb begin
    sec_log_next = sec_log_reg;
    ded_log_next = ded_log_reg;
    if (ecc_event.sec) begin
      sec_log_next = ecc_event.block;
    end
    if (ecc_event.ded) begin
      ded_log_next = ecc_event.block;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_log_reg <= `RST_BYTE;
      ded_log_reg <= `RST_BYTE;
    end else begin
      sec_log_reg <= sec_log_next;
      ded_log_reg <= ded_log_next;
    end
  end

  // Hardware events for the sticky status bits
  always_comb begin
    hw_set                   = '0;
    hw_set[`IRQ_SEC_BIT]     = ecc_event.sec;
    hw_set[`IRQ_DED_BIT]     = ecc_event.ded;
    hw_set[`IRQ_DONE_BIT]    = seq_done;
    hw_set[`IRQ_REFUSED_BIT] = start_req && !keys_ok;
  end

  // Write one to clear; an event in the same cycle wins over the clear
  always_comb begin
    status_next = status_reg;
    if (status_wr) begin
      status_next = status_reg & ~wr_byte[`IRQ_W-1:0];
    end
    status_next = status_next | hw_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= `RST_IRQ;
    end else begin
      status_reg <= status_next;
    end
  end

  // Level interrupt while any unmasked status bit stands
  assign irq = |(status_reg & mask_reg);

  // Programming engine; start bit reads its busy flag and clears when done
  // It takes the page written alongside the start bit, not the older copy
  otp_program_sequencer u_sequencer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (seq_start),
    .page     (page_next),
    .otp_done (otp_done),
    .busy     (seq_busy),
    .done     (seq_done),
    .otp_prog (otp_prog)
  );

endmodule : otp_program_unlock_control

// file: src/otp_unlock_params.svh
`ifndef OTP_UNLOCK_PARAMS_SVH
`define OTP_UNLOCK_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_W              11
`define IDX_KEY_ONE_A      11'h300
`define IDX_KEY_ONE_D      11'h303
`define IDX_PROG_CTRL      11'h30B
`define IDX_KEY_TWO_A      11'h352
`define IDX_KEY_TWO_D      11'h355
`define IDX_SEC_LOG        11'h7A0
`define IDX_DED_LOG        11'h7A1
`define IDX_IRQ_STATUS     11'h7B0
`define IDX_IRQ_MASK       11'h7B1

// Program control fields
`define CTRL_START_BIT     0
`define CTRL_PAGE_BIT      1

// Interrupt status and mask fields
`define IRQ_W              4
`define IRQ_SEC_BIT        0
`define IRQ_DED_BIT        1
`define IRQ_DONE_BIT       2
`define IRQ_REFUSED_BIT    3

// Reset values
`define RST_BYTE           8'h00
`define RST_KEY            32'h00000000
`define RST_IRQ            4'h0
`define RST_STAGE          3'h0

// Key entry stage that means all four bytes arrived in order
`define STAGE_FULL         3'h4

`endif

// file: src/otp_unlock_pkg.sv
package otp_unlock_pkg;

  // Programming engine states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PROGRAM,
    SEQ_FINISH
  } seq_state_t;

  // Request to the OTP array programmer
  typedef struct packed {
    logic req;
    logic page;
  } otp_prog_t;

  // Error report from the OTP read path
  typedef struct packed {
    logic       sec;
    logic       ded;
    logic [7:0] block;
  } ecc_event_t;

endpackage : otp_unlock_pkg

// file: verif/otp_program_unlock_control_tb.sv
`timescale 1ns/10ps
`include "otp_unlock_params.svh"
module otp_program_unlock_control_tb;
  import otp_unlock_pkg::*;
  localparam logic [31:0] K1 = 32'h3C5A96E1;
  localparam logic [31:0] K2 = 32'h7E81D24B;
  logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout, otp_done, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  ecc_event_t  ecc_event;
  otp_prog_t   otp_prog;
  integer      err_count, cmp_count, seed;
  logic [3:0]  sts, msk;
  logic [7:0]  blk;
  int          st[2];
  logic [31:0] kv[2];
  otp_program_unlock_control #(.KEY_ONE_CODE(K1), .KEY_TWO_CODE(K2)) u_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ecc_event(ecc_event), .otp_done(otp_done),
    .otp_prog(otp_prog), .irq(irq));
  // 25 MHz clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    test_done();
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      test_done();
    end
  endtask : wait_rdy
  // One single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [10:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {19'h0, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  // Key byte write plus the reference entry tracker
  task automatic wkey(input int k, input int n, input logic [7:0] b);
    bus(1'b1, (k ? `IDX_KEY_TWO_A : `IDX_KEY_ONE_A) + 11'(n), {24'h0, b});
    if (n == 0) begin
      kv[k] = {b, 24'h0};
      st[k] = 1;
    end else if (n == st[k]) begin
      kv[k][31-8*n -: 8] = b;
      st[k]++;
    end else begin
      st[k] = 0;
    end
  endtask : wkey
  task automatic wkeys(input int k, input logic [31:0] v);
    for (int n = 0; n < 4; n++) wkey(k, n, v[31-8*n -: 8]);
  endtask : wkeys
  task automatic chk_st();
    bus(1'b0, `IDX_IRQ_STATUS, 32'h0);
    chk("status", rd, {28'h0, sts});
    chk("irq", 32'(irq), 32'((sts & msk) != 4'h0));
    chk("hresp", 32'(hresp), 32'h0);
  endtask : chk_st
  // Start attempt; keys relock whatever the outcome
  task automatic start(input logic pg);
    logic ok;
    ok = st[0] == 4 && st[1] == 4 && kv[0] == K1 && kv[1] == K2;
    st[0] = 0;
    st[1] = 0;
    bus(1'b1, `IDX_PROG_CTRL, {30'h0, pg, 1'b1});
    #1;
    chk("req", 32'(otp_prog.req), 32'(ok));
    if (ok) begin
      chk("page", 32'(otp_prog.page), 32'(pg));
      bus(1'b0, `IDX_PROG_CTRL, 32'h0);
      chk("busy", rd, {30'h0, pg, 1'b1});
      otp_done <= 1'b1;
      @(posedge hclk);
      otp_done <= 1'b0;
      repeat (3) @(posedge hclk);
      sts[2] = 1'b1;
    end else begin
      sts[3] = 1'b1;
    end
    bus(1'b0, `IDX_PROG_CTRL, 32'h0);
    chk("ready", 32'(rd[0]), 32'h0);
    chk("idle", 32'(otp_prog.req), 32'h0);
  endtask : start
  logic [10:0] rl[5] = '{`IDX_PROG_CTRL, `IDX_SEC_LOG, `IDX_DED_LOG, `IDX_IRQ_STATUS,
    `IDX_IRQ_MASK};
  // Main sequence
  initial begin
    seed = 65250;
    err_count = 0;
    cmp_count = 0;
    sts = 4'h0;
    msk = 4'h0;
    st = '{0, 0};
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    otp_done = 1'b0;
    ecc_event = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, rl[i], 32'h0);
      chk("reset", rd, 32'h0);
    end
    wkeys(0, K1);
    wkeys(1, K2);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, (i < 4 ? `IDX_KEY_ONE_A : `IDX_KEY_TWO_A - 11'h4) + 11'(i), 32'h0);
      chk("key", rd, 32'h0);
    end
    bus(1'b0, 11'h7FF, 32'h0);
    chk("unmapped", rd, 32'h0);
    start(1'b0);
    start(1'b0);
    wkeys(0, K1);
    wkeys(1, K2);
    start(1'b1);
    wkeys(0, K1);
    wkeys(1, $random(seed));
    start(1'b0);
    wkey(0, 0, K1[31:24]);
    wkey(0, 2, K1[15:8]);
    wkey(0, 1, K1[23:16]);
    wkey(0, 3, K1[7:0]);
    wkeys(1, K2);
    start(1'b0);
    chk_st();
    msk = 4'h8;
    bus(1'b1, `IDX_IRQ_MASK, {28'h0, msk});
    chk_st();
    bus(1'b1, `IDX_IRQ_STATUS, 32'h8);
    sts[3] = 1'b0;
    chk_st();
    // Error log events with random block numbers
    for (int i = 0; i < 4; i++) begin
      rd = $random(seed);
      blk = rd[7:0];
      ecc_event <= {i[0], ~i[0], blk};
      @(posedge hclk);
      ecc_event <= '0;
      sts[i[0] ? 0 : 1] = 1'b1;
      bus(1'b0, i[0] ? `IDX_SEC_LOG : `IDX_DED_LOG, 32'h0);
      chk("log", rd, {24'h0, blk});
    end
    msk = 4'h3;
    bus(1'b1, `IDX_IRQ_MASK, {28'h0, msk});
    chk_st();
    bus(1'b1, `IDX_IRQ_STATUS, {28'h0, sts});
    sts = 4'h0;
    chk_st();
    test_done();
  end
endmodule : otp_program_unlock_control_tb

// file: verif/otp_unlock_properties.sv
`timescale 1ns/10ps
`include "otp_unlock_params.svh"
// Port-level checks of the register bus and programming handshake
module otp_unlock_checker (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire logic                       hreadyout,
  input wire otp_unlock_pkg::ecc_event_t ecc_event,
  input wire logic                       otp_done,
  input wire otp_unlock_pkg::otp_prog_t  otp_prog,
  input wire logic                       irq
);
  import otp_unlock_pkg::*;
  logic [10:0] idx;
  logic        rtk;
  logic        cdp;
  logic        go_seen;
  logic        pg_seen;
  logic [7:0]  sec_blk;
  logic [7:0]  ded_blk;
  assign idx = haddr[12:2];
  assign rtk = hsel && htrans[1] && hready && !hwrite;
  // Shadow of control writes and error logs, updated at the same edges as the block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cdp <= 1'b0;
      go_seen <= 1'b0;
      pg_seen <= 1'b0;
      sec_blk <= 8'h00;
      ded_blk <= 8'h00;
    end else begin
      cdp <= hsel && htrans[1] && hready && hwrite && idx == `IDX_PROG_CTRL;
      go_seen <= cdp && hwdata[`CTRL_START_BIT];
      pg_seen <= hwdata[`CTRL_PAGE_BIT];
      if (ecc_event.sec) sec_blk <= ecc_event.block;
      if (ecc_event.ded) ded_blk <= ecc_event.block;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  reset_quiet_a: assert property ($rose(hresetn) |-> !otp_prog.req && !irq && hreadyout)
    else $error("outputs busy after reset");
  read_wait_a: assert property (rtk |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  key_read_zero_a: assert property (rtk && (idx inside {[`IDX_KEY_ONE_A:`IDX_KEY_ONE_D],
    [`IDX_KEY_TWO_A:`IDX_KEY_TWO_D]}) |-> ##2 hrdata == 32'h00000000)
    else $error("key byte read not zero");
  ctrl_rsvd_a: assert property (rtk && idx == `IDX_PROG_CTRL |-> ##2 hrdata[31:2] == 30'h0)
    else $error("reserved control bits set");
  sec_log_a: assert property (rtk && idx == `IDX_SEC_LOG |->
    ##2 hrdata == {24'h0, $past(sec_blk)})
    else $error("corrected block log wrong");
  ded_log_a: assert property (rtk && idx == `IDX_DED_LOG |->
    ##2 hrdata == {24'h0, $past(ded_blk)})
    else $error("uncorrectable block log wrong");
  start_cause_a: assert property ($rose(otp_prog.req) |-> go_seen)
    else $error("programming began without start write");
  start_page_a: assert property ($rose(otp_prog.req) |-> otp_prog.page == pg_seen)
    else $error("programmed page differs from written");
  page_hold_a: assert property (otp_prog.req && $past(otp_prog.req) |-> $stable(otp_prog.page))
    else $error("page moved while programming");
  done_drop_a: assert property (otp_prog.req && otp_done |=> !otp_prog.req)
    else $error("request held after finish");
  cover property ($rose(otp_prog.req) && otp_prog.page);
  cover property ($rose(irq));
  cover property (rtk && idx == `IDX_SEC_LOG);
endmodule : otp_unlock_checker

bind otp_program_unlock_control otp_unlock_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .ecc_event(ecc_event),
  .otp_done(otp_done), .otp_prog(otp_prog), .irq(irq));
